// ==== shared/spm_defs.svh ====
// offsets, field positions, pin indices and reset values of the shared pin mux
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
`define SPM_NPIN 22
`define SPM_NSYNC 23
`define SPM_A0 0
`define SPM_B0 4
`define SPM_B3 7
`define SPM_DIR 10
`define SPM_TCLK 11
`define SPM_C0 12
`define SPM_CLKO 13
`define SPM_XF 14
`define SPM_BR 15
`define SPM_CAP 16
`define SPM_TX 20
`define SPM_RX 21
`define SPM_PDP 22
`define SPM_IN_FUNCS 22'h3f9c0f
`define SPM_OFF_PORTA 8'h00
`define SPM_OFF_PORTB 8'h04
`define SPM_OFF_PORTC 8'h08
`define SPM_OFF_PORTD 8'h0c
`define SPM_OFF_SYS 8'h10
`define SPM_OFF_SACT 8'h14
`define SPM_MASK_A 8'h0f
`define SPM_MASK_B 8'hff
`define SPM_MASK_C 8'hff
`define SPM_MASK_D 8'h03
`define SPM_FSEL_LSB 16
`define SPM_DIR_LSB 8
`define SPM_PIN_LSB 24
`define SPM_RST_FSEL_C 8'h0c
`define SPM_C_CLKO_BIT 17
`define SPM_SYS_XF 2
`define SPM_SYS_PDPEN 3
`define SPM_SYS_QEP 4
`define SPM_SYS_PDPST 8
`define SPM_RST_SYS 32'h00000008
`define SPM_RST_SACT 32'h00000000
`endif

// ==== shared/spm_pkg.sv ====
// types shared by the pin mux and its bench
`include "spm_defs.svh"
package spm_pkg;
  typedef struct packed {
    logic [`SPM_NPIN-1:0] o;
    logic [`SPM_NPIN-1:0] oe;
  } spm_pad_s;
  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe;
  } spm_fcmp_s;
  typedef struct packed {
    logic [3:0] adc_en;
    logic tmr_down;
    logic tmr_clk;
    logic conv_start;
    logic [3:0] cap;
    logic [1:0] quadrature_encoder_input;
    logic branch_take;
    logic sci_rx;
  } spm_periph_s;
  typedef enum logic [1:0] {
    SPM_ACT_LOW = 2'h0,
    SPM_ACT_ALOW = 2'h1,
    SPM_ACT_AHIGH = 2'h2,
    SPM_ACT_HIGH = 2'h3
  } spm_act_e;
endpackage : spm_pkg

// ==== design/spm_pin_mux.sv ====
// shared-function pin multiplexer with wishbone port registers
//
// Behaviour
// (RULE_01) shared pins leave any reset as digital inputs, function off, except flag, branch and clock out pins.
// (RULE_02) port A pins may route to the first or second converter instead.
// (RULE_03) simple-compare pin level comes from compare unit and action setting.
// (RULE_04) simple-compare pins float while unmasked protect input is low.
// (RULE_05) timer compare pins float while unmasked protect input is low.
// (RULE_06) direction pin low counts timers up, high counts down; board drives it.
// (RULE_07) selected timer clock pin feeds the general-purpose timers.
// (RULE_08) selected converter start pin triggers a conversion.
// (RULE_09) capture pins 1,2 capture or quadrature; pins 3,4 capture only.
// (RULE_10) external flag drives latched software level; default after every reset.
// (RULE_11) branch input pin defaults to branch-control input after every reset.
// (RULE_12) branch poll finding the pin low takes the branch.
// (RULE_13) clock out pin carries selected clock; default after power-on reset.
// (RULE_14) serial pins carry serial transmit/receive or general-purpose I/O.
// (RULE_15) full-compare pins float on unmasked protect low and during reset.
// (RULE_16) in digital mode direction and level come from port registers.
`timescale 1ns/1ps
`include "spm_defs.svh"
module spm_pin_mux import spm_pkg::*; (
  input wire logic clk_i, // core clock, 50 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic por_i, // high while the reset is a power-on one
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [`SPM_NPIN-1:0] pad_i, // pin levels
  output spm_pad_s pad_o, // pin drive and enables
  input wire logic power_drive_protect_irq_n_i, // protect input, active low
  input wire logic [2:0] scmp_i, // simple compare matches
  input wire logic [2:0] tcmp_i, // timer compare levels
  input wire logic [5:0] fcmp_i, // full compare levels
  output spm_fcmp_s fcmp_o, // full compare pins
  input wire logic [3:0] clk_src_i, // candidate clock levels
  input wire logic sci_tx_i, // serial transmit data
  input wire logic branch_poll_i, // branch-on-input instruction polls
  output spm_periph_s periph_o // to the peripherals
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [31:0] port_r [4];
  logic [31:0] sys_r;
  logic [31:0] sact_r;
  logic [`SPM_NSYNC-1:0] s1, s2, s3, filt;
  logic start_prev;
  logic [`SPM_NPIN-1:0] fs, dir, dout;
  logic trip;
  spm_pad_s next_pad;
  logic [31:0] next_rd;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [7:0] pin_mask(input logic [1:0] p);
    unique case (p)
      2'h0: return `SPM_MASK_A;
      2'h1: return `SPM_MASK_B;
      2'h2: return `SPM_MASK_C;
      2'h3: return `SPM_MASK_D;
    endcase
  endfunction : pin_mask

  // output level under the simple action setting
  function automatic logic act_level(input spm_act_e a, input logic m);
    unique case (a)
      SPM_ACT_LOW: return 1'b0;
      SPM_ACT_ALOW: return ~m;
      SPM_ACT_AHIGH: return m;
      SPM_ACT_HIGH: return 1'b1;
    endcase
  endfunction : act_level

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      filt <= '1;
    end else begin
      s1 <= {power_drive_protect_irq_n_i, pad_i};
      s2 <= s1;
      s3 <= s2;
      filt <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end
  end

  // flat views of the port registers, pin order A, B, C, serial
  assign fs = {port_r[3][17:16], port_r[2][23:16], port_r[1][23:16], port_r[0][19:16]};
  assign dir = {port_r[3][9:8], port_r[2][15:8], port_r[1][15:8], port_r[0][11:8]};
  assign dout = {port_r[3][1:0], port_r[2][7:0], port_r[1][7:0], port_r[0][3:0]};
  assign trip = sys_r[`SPM_SYS_PDPEN] & ~filt[`SPM_PDP];

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, unmapped reads give zero; unmapped writes below 0x10 go to the port picked by address bits 3:2, others are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= next_rd;
    end
  end

  always_comb begin
    next_rd = 32'h0;
    unique case (wb_adr_i)
      `SPM_OFF_PORTA: next_rd = {4'h0, filt[3:0], port_r[0][23:0]};
      `SPM_OFF_PORTB: next_rd = {filt[11:4], port_r[1][23:0]};
      `SPM_OFF_PORTC: next_rd = {filt[19:12], port_r[2][23:0]};
      `SPM_OFF_PORTD: next_rd = {6'h0, filt[21:20], port_r[3][23:0]};
      `SPM_OFF_SYS: next_rd = sys_r | {23'h0, ~filt[`SPM_PDP], 8'h0};
      `SPM_OFF_SACT: next_rd = sact_r;
      default: next_rd = 32'h0;
    endcase
  end

  // port registers; every reset leaves pins as inputs except flag and branch; clock out is set by power-on reset and kept by warm reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_r[0] <= 32'h0; // see RULE_01
      port_r[1] <= 32'h0;
      port_r[3] <= 32'h0;
      port_r[2] <= {8'h0, `SPM_RST_FSEL_C, 16'h0}; // see RULE_10 see RULE_11
      port_r[2][`SPM_C_CLKO_BIT] <= por_i | port_r[2][`SPM_C_CLKO_BIT]; // see RULE_13
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[7:4] == 4'h0) begin
      port_r[wb_adr_i[3:2]] <= merge(port_r[wb_adr_i[3:2]], wb_dat_i, wb_sel_i)
        & {8'h0, {3{pin_mask(wb_adr_i[3:2])}}};
    end
  end

  // system control: clock source, flag level, protect enable, quadrature mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_r <= `SPM_RST_SYS;
      sact_r <= `SPM_RST_SACT;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      if (wb_adr_i == `SPM_OFF_SYS) begin
        sys_r <= merge(sys_r, wb_dat_i, wb_sel_i) & 32'h0000001f;
      end
      if (wb_adr_i == `SPM_OFF_SACT) begin
        sact_r <= merge(sact_r, wb_dat_i, wb_sel_i) & 32'h0000003f;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: port registers by default, functions override
  always_comb begin
    next_pad.o = dout; // see RULE_16
    next_pad.oe = dir & ~(fs & `SPM_IN_FUNCS); // see RULE_02
    for (int k = 0; k < 3; k++) begin
      if (fs[`SPM_B0 + k]) begin
        next_pad.o[`SPM_B0 + k] = act_level(spm_act_e'(sact_r[2*k +: 2]), scmp_i[k]); // see RULE_03
        next_pad.oe[`SPM_B0 + k] = ~trip; // see RULE_04
      end
      if (fs[`SPM_B3 + k]) begin
        next_pad.o[`SPM_B3 + k] = tcmp_i[k];
        next_pad.oe[`SPM_B3 + k] = ~trip; // see RULE_05
      end
    end
    // the clock is resampled here, so only clocks below half the core rate pass cleanly
    if (fs[`SPM_CLKO]) begin
      next_pad.o[`SPM_CLKO] = clk_src_i[sys_r[1:0]]; // see RULE_13
      next_pad.oe[`SPM_CLKO] = 1'b1;
    end
    if (fs[`SPM_XF]) begin
      next_pad.o[`SPM_XF] = sys_r[`SPM_SYS_XF]; // see RULE_10
      next_pad.oe[`SPM_XF] = 1'b1;
    end
    if (fs[`SPM_TX]) begin
      next_pad.o[`SPM_TX] = sci_tx_i; // see RULE_14
      next_pad.oe[`SPM_TX] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= '0;
      fcmp_o <= '0; // see RULE_15
    end else begin
      pad_o <= next_pad;
      fcmp_o.o <= fcmp_i;
      fcmp_o.oe <= {6{~trip}}; // see RULE_15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral side; inputs of unselected functions rest at their idle levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_o <= '0;
      periph_o.sci_rx <= 1'b1;
      start_prev <= 1'b1;
    end else begin
      start_prev <= filt[`SPM_C0];
      periph_o.adc_en <= fs[3:0]; // see RULE_02
      periph_o.tmr_down <= fs[`SPM_DIR] & filt[`SPM_DIR]; // see RULE_06
      periph_o.tmr_clk <= fs[`SPM_TCLK] & filt[`SPM_TCLK]; // see RULE_07
      periph_o.conv_start <= fs[`SPM_C0] & filt[`SPM_C0] & ~start_prev; // see RULE_08
      periph_o.cap[3:2] <= fs[19:18] & filt[19:18];
      periph_o.cap[1:0] <= sys_r[`SPM_SYS_QEP] ? 2'h0 : fs[17:16] & filt[17:16]; // see RULE_09
      periph_o.quadrature_encoder_input <= sys_r[`SPM_SYS_QEP] ? fs[17:16] & filt[17:16] : 2'h0; // see RULE_09
      periph_o.branch_take <= branch_poll_i & fs[`SPM_BR] & ~filt[`SPM_BR]; // see RULE_12
      periph_o.sci_rx <= fs[`SPM_RX] ? filt[`SPM_RX] : 1'b1; // see RULE_14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rst_rel;
    rst_i ##1 !rst_i;
  endsequence

  property p_rst_inputs;
    disable iff (1'b0) s_rst_rel |=> (pad_o.oe & 22'h3f9fff) == 22'h0 && fs[12:0] == 13'h0;
  endproperty
  a_rst_inputs: assert property (p_rst_inputs) else $error("pin not input after reset"); // see RULE_01

  property p_xf_dflt;
    disable iff (1'b0) s_rst_rel |=> pad_o.oe[`SPM_XF] && !pad_o.o[`SPM_XF];
  endproperty
  a_xf_dflt: assert property (p_xf_dflt) else $error("flag pin not driven after reset"); // see RULE_10

  property p_br_dflt;
    disable iff (1'b0) rst_i |=> fs[`SPM_BR] && fs[`SPM_XF];
  endproperty
  a_br_dflt: assert property (p_br_dflt) else $error("branch pin not in branch mode"); // see RULE_11

  property p_adc;
    fs[0] |=> periph_o.adc_en[0] && !pad_o.oe[0];
  endproperty
  a_adc: assert property (p_adc) else $error("analog pin still driven"); // see RULE_02

  property p_sact;
    fs[`SPM_B0] && !trip && sact_r[1:0] == 2'h1 |=> pad_o.oe[`SPM_B0] && pad_o.o[`SPM_B0] == !$past(scmp_i[0]);
  endproperty
  a_sact: assert property (p_sact) else $error("active low compare level wrong"); // see RULE_03

  property p_scmp_hiz;
    trip |=> (pad_o.oe[6:4] & $past(fs[6:4])) == 3'h0;
  endproperty
  a_scmp_hiz: assert property (p_scmp_hiz) else $error("simple compare pin driven on trip"); // see RULE_04

  property p_tcmp_hiz;
    trip |=> (pad_o.oe[9:7] & $past(fs[9:7])) == 3'h0 && fcmp_o.oe == 6'h0;
  endproperty
  a_tcmp_hiz: assert property (p_tcmp_hiz) else $error("compare pin driven on trip"); // see RULE_05

  property p_fcmp_on;
    !rst_i && !trip ##1 !trip |-> fcmp_o.oe == 6'h3f;
  endproperty
  a_fcmp_on: assert property (p_fcmp_on) else $error("full compare pin floats"); // see RULE_15

  property p_dir;
    fs[`SPM_DIR] && filt[`SPM_DIR] |=> periph_o.tmr_down;
  endproperty
  a_dir: assert property (p_dir) else $error("timers not counting down"); // see RULE_06

  property p_tclk;
    fs[`SPM_TCLK] |=> periph_o.tmr_clk == $past(filt[`SPM_TCLK]);
  endproperty
  a_tclk: assert property (p_tclk) else $error("timer clock not passed"); // see RULE_07

  sequence s_start_pulse;
    periph_o.conv_start ##1 !periph_o.conv_start;
  endsequence

  property p_start;
    fs[`SPM_C0] && filt[`SPM_C0] && !start_prev |=> s_start_pulse;
  endproperty
  a_start: assert property (p_start) else $error("conversion start not one pulse"); // see RULE_08

  property p_qep;
    sys_r[`SPM_SYS_QEP] |=> periph_o.cap[1:0] == 2'h0 && periph_o.quadrature_encoder_input == $past(fs[17:16] & filt[17:16]);
  endproperty
  a_qep: assert property (p_qep) else $error("quadrature routing wrong"); // see RULE_09

  property p_branch;
    branch_poll_i && fs[`SPM_BR] |=> periph_o.branch_take == !$past(filt[`SPM_BR]);
  endproperty
  a_branch: assert property (p_branch) else $error("branch decision wrong"); // see RULE_12

  property p_clko;
    !rst_i && fs[`SPM_CLKO] |=> pad_o.oe[`SPM_CLKO] && pad_o.o[`SPM_CLKO] == $past(clk_src_i[sys_r[1:0]]);
  endproperty
  a_clko: assert property (p_clko) else $error("clock out not selected source"); // see RULE_13

  property p_tx;
    fs[`SPM_TX] |=> pad_o.oe[`SPM_TX] && pad_o.o[`SPM_TX] == $past(sci_tx_i);
  endproperty
  a_tx: assert property (p_tx) else $error("serial transmit not on pin"); // see RULE_14

  property p_gpio;
    !fs[5] |=> pad_o.oe[5] == $past(dir[5]) && pad_o.o[5] == $past(dout[5]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("port pin not from registers"); // see RULE_16

endmodule : spm_pin_mux

// ==== test/spm_board.sv ====
// board-side model of the shared pins: pull-ups plus levels the bench asks the board to drive
`timescale 1ns/1ps
module spm_board import spm_pkg::*; (
  input wire spm_pad_s dev_i, // device pin drive and enables
  input wire logic [21:0] drv_i, // board drives this pin
  input wire logic [21:0] lev_i, // level the board drives
  output logic [21:0] pin_o // resolved pin levels
);
  ////////////////////////////////////////////////////////////////////////////////
  // every shared pin has a board pull-up, so a floating pin never reads as a stale level;
  // the board never fights the device: it only drives pins whose enable is low
  always_comb begin
    for (int k = 0; k < 22; k++) begin
      pin_o[k] = dev_i.oe[k] ? dev_i.o[k] : (drv_i[k] ? lev_i[k] : 1'b1);
    end
  end
endmodule : spm_board

// ==== test/testbench.sv ====
// self-checking bench of the shared pin mux
`timescale 1ns/1ps
module testbench import spm_pkg::*;;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [21:0] m, oe, o; logic [23:0] r;} spm_row_s;
  logic clk_i = 0, rst_i = 1, por_i = 1, cyc = 0, stb = 0, we = 0, pdp_n = 1, poll = 0, tx = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, csrc = 4'h5;
  logic [31:0] wd = 32'h0, rd;
  logic [2:0] scmp = 3'h5, tcmp = 3'h5;
  logic [5:0] fcmp = 6'h2a;
  logic [21:0] drv = 22'h0, lev = 22'h0, pin;
  logic [31:0] wb_q;
  logic ack;
  spm_pad_s pad;
  spm_fcmp_s fc;
  spm_periph_s per;
  integer n_errors = 0, checked = 0, i, k;
  // address, data, compare mask, expected enables, expected levels, expected read-back
  spm_row_s rows [6] = '{
    '{8'h00, 32'h00000f05, 22'h00000f, 22'h00000f, 22'h000005, 24'h000f05},
    '{8'h14, 32'h00000039, 22'h00000f, 22'h00000f, 22'h000005, 24'h000039},
    '{8'h04, 32'h003f0000, 22'h0003f0, 22'h0003f0, 22'h0002c0, 24'h3f0000},
    '{8'h14, 32'h00000006, 22'h000070, 22'h000070, 22'h000030, 24'h000006},
    '{8'h0c, 32'h00000302, 22'h300000, 22'h300000, 22'h200000, 24'h000302},
    '{8'h40, 32'hffffffff, 22'h30000f, 22'h30000f, 22'h200005, 24'h000000}};

  spm_pin_mux spm_pin_mux_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wb_q), .wb_ack_o(ack),
    .pad_i(pin), .pad_o(pad), .power_drive_protect_irq_n_i(pdp_n), .scmp_i(scmp), .tcmp_i(tcmp),
    .fcmp_i(fcmp), .fcmp_o(fc), .clk_src_i(csrc), .sci_tx_i(tx), .branch_poll_i(poll), .periph_o(per));
  spm_board spm_board_i (.dev_i(pad), .drv_i(drv), .lev_i(lev), .pin_o(pin));

  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz core clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one classic cycle; the wait is bounded so a missing ack cannot hang the run
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = wb_q;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      n_errors++;
      stop_test();
    end
  endtask : wb

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    chk(fc.oe, 0);
    chk(pad.oe, 0);
    rst_i <= 1'b0; por_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(pad.oe, 22'h006000);
    chk(pad.o[14], 0);
    chk(per.sci_rx, 1);
    chk(fc.o, 6'h2a);
    wb(0, 8'h08, 0);
    chk(rd[23:16], 8'h0e);
    wb(0, 8'h10, 0);
    chk(rd[8:0], 9'h008);
    // ordinary register cases
    for (i = 0; i < 6; i++) begin
      wb(1, rows[i].a, rows[i].d);
      repeat (2) @(posedge clk_i);
      chk(pad.oe & rows[i].m, rows[i].oe);
      chk(pad.o & rows[i].m, rows[i].o);
      wb(0, rows[i].a, 0);
      chk(rd[23:0], rows[i].r);
    end
    chk(pad.o[13], csrc[0]);
    wb(1, 8'h10, 32'h0000000d);
    repeat (4) @(posedge clk_i);
    chk(pad.o[14:13], 2'b10);
    // protect input low floats every compare pin while unmasked
    pdp_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(pad.oe[9:4], 0);
    chk(fc.oe, 0);
    wb(0, 8'h10, 0);
    chk(rd[8], 1);
    wb(1, 8'h10, 32'h00000005);
    repeat (4) @(posedge clk_i);
    chk(pad.oe[9:4], 6'h3f);
    pdp_n <= 1'b1;
    // input functions with the board driving the pins
    wb(1, 8'h04, 32'h00ff0000);
    wb(1, 8'h00, 32'h000f0000);
    wb(1, 8'h08, 32'h00ff0000);
    wb(1, 8'h0c, 32'h00030000);
    wb(1, 8'h10, 32'h0000001d);
    drv <= 22'h2f9c00;
    lev <= 22'h0a0c00;
    tx <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(per.tmr_down, 1);
    chk(per.tmr_clk, 1);
    chk(per.adc_en, 4'hf);
    chk(pad.oe[3:0], 0);
    chk(per.cap, 4'h8);
    chk(per.quadrature_encoder_input, 2'h2);
    chk(per.sci_rx, 0);
    chk(pad.o[20] & pad.oe[20], 1);
    k = 0;
    lev[12] <= 1'b1;
    repeat (10) begin
      @(posedge clk_i);
      k = k + per.conv_start;
    end
    chk(k, 1);
    for (i = 0; i < 2; i++) begin
      lev[15] <= i[0];
      repeat (8) @(posedge clk_i);
      poll <= 1'b1;
      @(posedge clk_i);
      poll <= 1'b0;
      @(posedge clk_i);
      chk(per.branch_take, !i[0]);
    end
    // warm reset keeps clock out, restores flag and branch, clears the rest
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(pad.oe, 22'h006000);
    wb(0, 8'h08, 0);
    chk(rd[23:16], 8'h0e);
    wb(0, 8'h00, 0);
    chk(rd[23:0], 0);
    stop_test();
  end
endmodule : testbench
